// >>> hcp_defs.svh
`ifndef HCP_DEFS_SVH
`define HCP_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets.
// ----------------------------------------------------------------
`define HCP_A_VID_LO   8'h01
`define HCP_A_VID_HI   8'h02
`define HCP_A_PID_LO   8'h03
`define HCP_A_PID_HI   8'h04
`define HCP_A_DEVCFG   8'h05
`define HCP_A_CHGSUP   8'h06
`define HCP_A_REMOVE   8'h07
`define HCP_A_DEVCFG2  8'h0A
`define HCP_A_CHGCTL   8'hF2

// ----------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------
`define HCP_DEVCFG_PSW_N   3
`define HCP_DEVCFG_GANGED  4
`define HCP_DC2_AUTO_DIS_N 1
`define HCP_DC2_HICUR      4
`define HCP_DC2_POLARITY   5
`define HCP_CHGCTL_DLY_LO  1
`define HCP_CHGCTL_DLY_HI  3

// ----------------------------------------------------------------
// Reset values and field masks.
// ----------------------------------------------------------------
`define HCP_RST_BYTE       8'h00
`define HCP_OTP_MASK_ID    8'hFF
`define HCP_OTP_MASK_NONE  8'h00
`define HCP_OTP_MASK_RMV   8'h03
`define HCP_OTP_MASK_DC2   8'h12
`define HCP_OTP_MASK_CTL   8'h0E
`define HCP_STRAP_CAP_CNT  2'h2

`endif

// >>> hcp_pkg.sv
package hcp_pkg;

	// Battery charging signalling mode of one downstream port.
	typedef enum logic [2:0] {
		HCP_MODE_NONE  = 3'b000,
		HCP_MODE_DIV5  = 3'b001,
		HCP_MODE_DIV10 = 3'b010,
		HCP_MODE_DCP   = 3'b011,
		HCP_MODE_CDP   = 3'b100
	} hcp_mode_t;

	// Byte-wide configuration register access.
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} hcp_reg_req_t;

	// Field write coming from the one-time-programmable memory loader.
	typedef struct packed {
		logic       valid;
		logic [7:0] addr;
		logic [7:0] data;
	} hcp_otp_wr_t;

	// Strap pin levels, sampled when global reset is released.
	typedef struct packed {
		logic       psw_n;
		logic       ganged;
		logic       polarity;
		logic       bus_mode_n;
		logic [1:0] charge;
	} hcp_strap_t;

endpackage : hcp_pkg

// >>> hcp_charge_port.sv
module hcp_charge_port (
	input  wire logic              i_clk,        // Hub clock.
	input  wire logic              i_rstn,       // Asynchronous reset, active low.
	input  wire logic              i_charge_en,  // Charging enabled for this port.
	input  wire logic              i_auto_dis_n, // High disables automatic selection.
	input  wire logic              i_vbus_hi,    // Synchronised VBUS above 4 V.
	input  wire logic              i_hicur,      // High-current divider setting.
	input  wire logic              i_div_pref,   // Attached device wants divider.
	output hcp_pkg::hcp_mode_t     o_mode,       // Selected charging mode.
	output logic                   o_dpdm_drive  // Data lines carry charger signalling.
);

	hcp_pkg::hcp_mode_t mode_r;
	hcp_pkg::hcp_mode_t mode_nxt;
	hcp_pkg::hcp_mode_t div_mode;

	// Divider advertises 10 W when high current is set, else 5 W.
	assign div_mode = i_hicur ? hcp_pkg::HCP_MODE_DIV10  // [RULE_08]
	                          : hcp_pkg::HCP_MODE_DIV5;  // [RULE_07]

	// Mode selection; automatic mode never yields the charging downstream mode.
	assign mode_nxt = !i_charge_en  ? hcp_pkg::HCP_MODE_NONE :
	                  !i_auto_dis_n ? (i_div_pref ? div_mode : hcp_pkg::HCP_MODE_DCP) :
	                  i_vbus_hi     ? hcp_pkg::HCP_MODE_CDP : hcp_pkg::HCP_MODE_DCP;

	// Mode and drive flags are registered.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			mode_r       <= hcp_pkg::HCP_MODE_NONE;
			o_dpdm_drive <= 1'b0;
		end else begin
			mode_r       <= mode_nxt;
			o_dpdm_drive <= (mode_nxt != hcp_pkg::HCP_MODE_NONE);
		end
	end

	assign o_mode = mode_r;

endmodule : hcp_charge_port

// >>> hcp_config.sv
// What this block does
// (RULE_01) No SuperSpeed downstream without upstream SuperSpeed.
// (RULE_02) Full/low-speed upstream also disables downstream high-speed.
// (RULE_03) One charge enable bit per port.
// (RULE_04) Mode from enable, auto-select and VBUS level.
// (RULE_05) Automatic selection active after reset.
// (RULE_06) Automatic mode picks divider or dedicated charging.
// (RULE_07) Divider advertises 5 W by default.
// (RULE_08) High-current bit makes divider advertise 10 W.
// (RULE_09) Automatic mode never selects charging downstream port.
// (RULE_10) Charge straps also enable port charging.
// (RULE_11) Active-low switching bit plus ganged select bit.
// (RULE_12) Ganged strap also selects ganged control.
// (RULE_13) Power enables follow the polarity bit.
// (RULE_14) Polarity strap also sets output polarity.
// (RULE_15) Programmable memory reaches only listed fields.
// (RULE_16) Programmed removable values are stored inverted.
// (RULE_17) Memory programmed by host vendor requests.
// (RULE_18) Straps sampled when global reset releases.
// (RULE_19) Disabled port drives no charger signalling.
`include "hcp_defs.svh"

module hcp_config (
	input  wire logic                 i_clk,          // Hub clock, 250 MHz.
	input  wire logic                 i_rstn,         // Global reset, active low.
	input  wire hcp_pkg::hcp_reg_req_t i_reg,         // Register access request.
	output logic [7:0]                o_reg_rdata,    // Read data, registered.
	input  wire hcp_pkg::hcp_otp_wr_t i_otp,          // Programmable memory field write.
	input  wire hcp_pkg::hcp_strap_t  i_straps,       // Strap pins.
	input  wire logic                 i_up_ss_cap,    // Upstream link runs SuperSpeed.
	input  wire logic                 i_up_hs_cap,    // Upstream link runs high-speed.
	input  wire logic [1:0]           i_port_pwr_req, // Per-port power request.
	input  wire logic [1:0]           i_vbus_hi,      // VBUS above 4 V pins.
	input  wire logic [1:0]           i_div_pref,     // Device wants divider signalling.
	output logic                      o_ds_ss_en,     // Downstream SuperSpeed allowed.
	output logic                      o_ds_hs_en,     // Downstream high-speed allowed.
	output logic [1:0]                o_pwr_en,       // Port power enable outputs.
	output hcp_pkg::hcp_mode_t        o_chg_mode [2], // Charging mode per port.
	output logic [1:0]                o_dpdm_drive,   // Charger signalling active.
	output logic [1:0]                o_removable,    // Port removable flags.
	output logic [2:0]                o_pwr_on_dly,   // Power switch power-on delay.
	output logic                      o_bus_mode_n,   // Sampled bus mode strap.
	output logic [15:0]               o_vid,          // Vendor identifier.
	output logic [15:0]               o_pid           // Product identifier.
);

	// ----------------------------------------------------------------
	// Register slots.
	// ----------------------------------------------------------------
	localparam int NREG = 9;
	localparam int SL_DEV = 4;
	localparam int SL_CHG = 5;
	localparam int SL_RMV = 6;
	localparam int SL_DC2 = 7;
	localparam int SL_CTL = 8;
	localparam logic [7:0] ADDR [NREG] = '{`HCP_A_VID_LO, `HCP_A_VID_HI, `HCP_A_PID_LO,
		`HCP_A_PID_HI, `HCP_A_DEVCFG, `HCP_A_CHGSUP, `HCP_A_REMOVE, `HCP_A_DEVCFG2,
		`HCP_A_CHGCTL};
	localparam logic [7:0] OMASK [NREG] = '{`HCP_OTP_MASK_ID, `HCP_OTP_MASK_ID,
		`HCP_OTP_MASK_ID, `HCP_OTP_MASK_ID, `HCP_OTP_MASK_NONE, `HCP_OTP_MASK_NONE,
		`HCP_OTP_MASK_RMV, `HCP_OTP_MASK_DC2, `HCP_OTP_MASK_CTL};

	logic [7:0]         regs_r [NREG];
	logic [7:0]         regs_nxt [NREG];
	logic [7:0]         strap_img [NREG];
	logic [7:0]         strap_msk [NREG];
	logic [7:0]         rd_chain [NREG+1];
	logic [NREG-1:0]    host_hit;
	logic [NREG-1:0]    otp_hit;
	logic [NREG-1:0]    slot_hit;
	hcp_pkg::hcp_strap_t strap_s1_r;
	hcp_pkg::hcp_strap_t strap_s2_r;
	logic [1:0]         cap_cnt_r;
	logic               cap_done_r;
	logic               cap_now;
	logic               bus_mode_n_r;

	// ----------------------------------------------------------------
	// Strap synchroniser and capture after reset release.
	// ----------------------------------------------------------------

	// Straps pass two flops; the capture waits until the second has filled.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			strap_s1_r <= '0;
			strap_s2_r <= '0;
			cap_cnt_r  <= 2'h0;
			cap_done_r <= 1'b0;
		end else begin
			strap_s1_r <= i_straps;
			strap_s2_r <= strap_s1_r;
			if (!cap_done_r) begin
				cap_cnt_r <= cap_cnt_r + 2'h1;
			end
			if (cap_now) begin
				cap_done_r <= 1'b1;
			end
		end
	end

	assign cap_now = !cap_done_r && (cap_cnt_r == `HCP_STRAP_CAP_CNT); // [RULE_18]

	// Bus mode strap value is held from the capture on.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			bus_mode_n_r <= 1'b1;
		end else if (cap_now) begin
			bus_mode_n_r <= strap_s2_r.bus_mode_n; // [RULE_18]
		end
	end

	// ----------------------------------------------------------------
	// Register file.
	// ----------------------------------------------------------------

	// Strap images load the fields that straps control at capture time.
	assign strap_img[SL_DEV] = 8'((strap_s2_r.psw_n << `HCP_DEVCFG_PSW_N)
		| (strap_s2_r.ganged << `HCP_DEVCFG_GANGED));            // [RULE_12]
	assign strap_img[SL_CHG] = {6'h00, strap_s2_r.charge};          // [RULE_10]
	assign strap_img[SL_DC2] = 8'(strap_s2_r.polarity << `HCP_DC2_POLARITY); // [RULE_14]
	assign strap_msk[SL_DEV] = 8'((1 << `HCP_DEVCFG_PSW_N) | (1 << `HCP_DEVCFG_GANGED));
	assign strap_msk[SL_CHG] = 8'h03;
	assign strap_msk[SL_DC2] = 8'(1 << `HCP_DC2_POLARITY);

	genvar k;
	generate
		for (k = 0; k < NREG; k++) begin : g_reg
			logic [7:0] otp_val;
			if (k != SL_DEV && k != SL_CHG && k != SL_DC2) begin : g_nostrap
				assign strap_img[k] = 8'h00;
				assign strap_msk[k] = 8'h00;
			end
			// Removable bits from programmable memory are stored inverted.
			if (k == SL_RMV) begin : g_inv
				assign otp_val = i_otp.data ^ 8'h03; // [RULE_16]
			end else begin : g_plain
				assign otp_val = i_otp.data;
			end
			assign slot_hit[k] = (i_reg.addr == ADDR[k]);
			assign host_hit[k] = i_reg.wr && slot_hit[k] && cap_done_r;
			assign otp_hit[k]  = i_otp.valid && (i_otp.addr == ADDR[k]); // [RULE_17]
			// Memory writes reach only the masked fields of each slot.
			assign regs_nxt[k] = cap_now     ? (regs_r[k] & ~strap_msk[k]) | strap_img[k] :
			                     host_hit[k] ? i_reg.wdata :
			                     otp_hit[k]  ? (regs_r[k] & ~OMASK[k]) | (otp_val & OMASK[k]) :
			                     regs_r[k];                                    // [RULE_15]
			assign rd_chain[k+1] = rd_chain[k] | (slot_hit[k] ? regs_r[k] : 8'h00);

			// Register holds its default until written or loaded from straps; auto-select bit resets low.
			always_ff @(posedge i_clk or negedge i_rstn) begin
				if (!i_rstn) begin
					regs_r[k] <= `HCP_RST_BYTE; // [RULE_05]
				end else begin
					regs_r[k] <= regs_nxt[k];
				end
			end
		end
	endgenerate

	assign rd_chain[0] = 8'h00;

	// Read data is captured on a read strobe; unmapped offsets read zero.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_reg_rdata <= 8'h00;
		end else if (i_reg.rd) begin
			o_reg_rdata <= rd_chain[NREG];
		end
	end

	// ----------------------------------------------------------------
	// Field decode.
	// ----------------------------------------------------------------
	logic       psw_n;
	logic       ganged;
	logic       polarity;
	logic       auto_dis_n;
	logic       hicur;
	logic [1:0] chg_en;
	logic [1:0] pwr_on;

	assign psw_n      = regs_r[SL_DEV][`HCP_DEVCFG_PSW_N];   // [RULE_11]
	assign ganged     = regs_r[SL_DEV][`HCP_DEVCFG_GANGED];  // [RULE_11]
	assign polarity   = regs_r[SL_DC2][`HCP_DC2_POLARITY];
	assign auto_dis_n = regs_r[SL_DC2][`HCP_DC2_AUTO_DIS_N];
	assign hicur      = regs_r[SL_DC2][`HCP_DC2_HICUR];
	assign chg_en     = regs_r[SL_CHG][1:0];                  // [RULE_03]

	assign o_vid        = {regs_r[1], regs_r[0]};
	assign o_pid        = {regs_r[3], regs_r[2]};
	assign o_removable  = regs_r[SL_RMV][1:0];
	assign o_pwr_on_dly = regs_r[SL_CTL][`HCP_CHGCTL_DLY_HI:`HCP_CHGCTL_DLY_LO];
	assign o_bus_mode_n = bus_mode_n_r;

	// ----------------------------------------------------------------
	// Speed gating and port power.
	// ----------------------------------------------------------------

	// Switching off means always powered; ganged joins all requests.
	assign pwr_on = !cap_done_r ? 2'b00 :
	                psw_n       ? 2'b11 :
	                ganged      ? {2{|i_port_pwr_req}} : i_port_pwr_req; // [RULE_11]

	// Speed enables follow upstream capability; power outputs follow polarity.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_ds_ss_en <= 1'b0;
			o_ds_hs_en <= 1'b0;
			o_pwr_en   <= 2'b00;
		end else begin
			o_ds_ss_en <= i_up_ss_cap && i_up_hs_cap;      // [RULE_01]
			o_ds_hs_en <= i_up_hs_cap;                     // [RULE_02]
			o_pwr_en   <= polarity ? pwr_on : ~pwr_on;    // [RULE_13]
		end
	end

	// ----------------------------------------------------------------
	// Per-port charging.
	// ----------------------------------------------------------------
	logic [1:0] vbus_s1_r;
	logic [1:0] vbus_s2_r;

	// VBUS comparator pins pass two flops.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			vbus_s1_r <= 2'b00;
			vbus_s2_r <= 2'b00;
		end else begin
			vbus_s1_r <= i_vbus_hi;
			vbus_s2_r <= vbus_s1_r;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	genvar p;
	generate
		for (p = 0; p < 2; p++) begin : g_port
			// Each port selects divider, dedicated or downstream charging.
			hcp_charge_port u_port (
				.i_clk       (i_clk),
				.i_rstn      (i_rstn),
				.i_charge_en (chg_en[p]),     // [RULE_19]
				.i_auto_dis_n(auto_dis_n),    // [RULE_04]
				.i_vbus_hi   (vbus_s2_r[p]),
				.i_hicur     (hicur),         // [RULE_08]
				.i_div_pref  (i_div_pref[p]), // [RULE_06]
				.o_mode      (o_chg_mode[p]),
				.o_dpdm_drive(o_dpdm_drive[p])
			);

			a_chg_off: assert property (!chg_en[p] |=> o_chg_mode[p] == hcp_pkg::HCP_MODE_NONE
				&& !o_dpdm_drive[p]) else $error("Disabled port still signals."); // [RULE_19]
			a_chg_cdp: assert property (chg_en[p] && auto_dis_n && vbus_s2_r[p]
				|=> o_chg_mode[p] == hcp_pkg::HCP_MODE_CDP)
				else $error("Downstream charging mode missed."); // [RULE_04]
			a_auto_nocdp: assert property (!auto_dis_n |=> o_chg_mode[p] != hcp_pkg::HCP_MODE_CDP)
				else $error("Downstream charging mode in automatic mode."); // [RULE_09]
			a_auto_pick: assert property (chg_en[p] && !auto_dis_n && !i_div_pref[p]
				|=> o_chg_mode[p] == hcp_pkg::HCP_MODE_DCP)
				else $error("Automatic mode failed to pick dedicated charging."); // [RULE_06]
			a_div_watts: assert property (chg_en[p] && !auto_dis_n && i_div_pref[p]
				|=> o_chg_mode[p] == ($past(hicur) ? hcp_pkg::HCP_MODE_DIV10
				: hcp_pkg::HCP_MODE_DIV5)) else $error("Divider power level wrong."); // [RULE_08]
		end
	endgenerate

	// ----------------------------------------------------------------
	// Checks.
	// ----------------------------------------------------------------
	sequence s_capture;
		cap_now ##1 cap_done_r;
	endsequence

	sequence s_otp_devcfg;
		i_otp.valid && i_otp.addr == `HCP_A_DEVCFG && !i_reg.wr && cap_done_r;
	endsequence

	a_ss_gate: assert property (!i_up_ss_cap |=> !o_ds_ss_en)
		else $error("SuperSpeed allowed without upstream support."); // [RULE_01]
	a_hs_gate: assert property (!i_up_hs_cap |=> !o_ds_hs_en && !o_ds_ss_en)
		else $error("High-speed allowed on full-speed upstream."); // [RULE_02]
	a_strap_load: assert property (s_capture |-> psw_n == $past(strap_s2_r.psw_n)
		&& ganged == $past(strap_s2_r.ganged) && polarity == $past(strap_s2_r.polarity)
		&& chg_en == $past(strap_s2_r.charge)) else $error("Straps not applied."); // [RULE_18]
	a_auto_reset: assert property (s_capture |-> !auto_dis_n)
		else $error("Automatic selection not active after reset."); // [RULE_05]
	a_otp_guard: assert property (s_otp_devcfg |=> $stable(regs_r[SL_DEV]))
		else $error("Programmable memory changed device configuration."); // [RULE_15]
	a_otp_invert: assert property (i_otp.valid && i_otp.addr == `HCP_A_REMOVE && !i_reg.wr
		&& cap_done_r |=> o_removable == ~$past(i_otp.data[1:0]))
		else $error("Removable bits not inverted."); // [RULE_16]
	a_pwr_pol: assert property (cap_done_r && !psw_n && !ganged
		|=> o_pwr_en == ($past(polarity) ? $past(i_port_pwr_req) : ~$past(i_port_pwr_req)))
		else $error("Power enable polarity wrong."); // [RULE_13]
	a_pwr_gang: assert property (cap_done_r && !psw_n && ganged
		|=> o_pwr_en[0] == o_pwr_en[1]) else $error("Ganged outputs differ."); // [RULE_11]

endmodule : hcp_config

// >>> hcp_port_partner.sv
// ----------------------------------------------------------------
// Power switches and attached portable devices on both ports.
// ----------------------------------------------------------------
module hcp_port_partner (
	input  wire logic       i_active_high, // Board switch enable sense.
	input  wire logic [1:0] i_pwr_en,      // Enable pins from the hub.
	input  wire logic [1:0] i_wants_div,   // Attached device asks for divider.
	output logic      [1:0] o_vbus_hi,     // Port VBUS above 4 V.
	output logic      [1:0] o_div_pref     // Device sees and accepts divider.
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [1:0] powered;

	// The switch closes on the enable sense that the board is built for.
	assign powered = i_active_high ? i_pwr_en : ~i_pwr_en;
	// An unpowered port has no VBUS, and its device cannot ask for anything.
	assign o_vbus_hi = powered;
	assign o_div_pref = powered & i_wants_div;
endmodule : hcp_port_partner

// >>> hcp_config_tb.sv
module hcp_config_tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// One table row: inputs, register values and expected outputs.
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       ss, hs;
		logic [7:0] r05, r06, r0a;
		logic [1:0] req, div, pwr;
		logic [2:0] m0, m1;
		logic       ss_e, hs_e;
	} hcp_row_t;

	logic                  i_clk = 1'b0;
	logic                  i_rstn = 1'b0;
	hcp_pkg::hcp_reg_req_t reg_q = '0;
	hcp_pkg::hcp_otp_wr_t  otp_q = '0;
	hcp_pkg::hcp_strap_t   straps = '0;
	logic                  up_ss = 1'b1;
	logic                  up_hs = 1'b1;
	logic [1:0]            pwr_req = 2'b00;
	logic [1:0]            wants = 2'b00;
	logic                  act_hi = 1'b1;
	logic [1:0]            vbus_hi, div_pref, pwr_en, dpdm, removable;
	logic [7:0]            rdata;
	logic [2:0]            dly;
	logic                  ss_en, hs_en, bus_mode_n;
	logic [15:0]           vid, pid;
	hcp_pkg::hcp_mode_t    chg_mode [2];
	int                    failures = 0;
	int                    checked = 0;
	int                    cycles = 0;
	hcp_row_t              rows [7];

	// Clock at 250 MHz.
	always #2 i_clk = ~i_clk;

	hcp_config dut (
		.i_clk(i_clk), .i_rstn(i_rstn), .i_reg(reg_q), .o_reg_rdata(rdata),
		.i_otp(otp_q), .i_straps(straps), .i_up_ss_cap(up_ss), .i_up_hs_cap(up_hs),
		.i_port_pwr_req(pwr_req), .i_vbus_hi(vbus_hi), .i_div_pref(div_pref),
		.o_ds_ss_en(ss_en), .o_ds_hs_en(hs_en), .o_pwr_en(pwr_en), .o_chg_mode(chg_mode),
		.o_dpdm_drive(dpdm), .o_removable(removable), .o_pwr_on_dly(dly),
		.o_bus_mode_n(bus_mode_n), .o_vid(vid), .o_pid(pid)
	);

	hcp_port_partner partner (
		.i_active_high(act_hi), .i_pwr_en(pwr_en), .i_wants_div(wants),
		.o_vbus_hi(vbus_hi), .o_div_pref(div_pref)
	);

	// ----------------------------------------------------------------
	// Reporting and bus tasks.
	// ----------------------------------------------------------------
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk) #1;
		reg_q = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge i_clk) #1;
		reg_q.wr = 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge i_clk) #1;
		reg_q = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge i_clk) #1;
		reg_q.rd = 1'b0;
		chk("register read", {8'h00, exp}, {8'h00, rdata});
	endtask : reg_rd

	task automatic otp_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk) #1;
		otp_q = '{valid: 1'b1, addr: a, data: d};
		@(posedge i_clk) #1;
		otp_q.valid = 1'b0;
	endtask : otp_wr

	task automatic settle();
		repeat (6) @(posedge i_clk);
		#1;
	endtask : settle

	// Resets with the given straps, checking the outputs held in reset.
	task automatic do_reset(input hcp_pkg::hcp_strap_t s);
		@(posedge i_clk) #1;
		i_rstn = 1'b0;
		straps = s;
		repeat (8) @(posedge i_clk);
		#1;
		chk("bus mode in reset", 16'h0001, {15'h0000, bus_mode_n});
		chk("power in reset", 16'h0000, {14'h0000, pwr_en});
		chk("modes in reset", 16'h0000, {10'h000, chg_mode[0], chg_mode[1]});
		i_rstn = 1'b1;
		settle();
	endtask : do_reset

	// Bounded run length.
	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			failures++;
			end_of_test();
		end
	end

	initial begin
		rows[0] = '{1, 1, 8'h00, 8'h03, 8'h20, 2'h3, 2'h1, 2'h3, 3'h1, 3'h3, 1, 1};
		rows[1] = '{0, 1, 8'h00, 8'h03, 8'h30, 2'h3, 2'h3, 2'h3, 3'h2, 3'h2, 0, 1};
		rows[2] = '{1, 0, 8'h00, 8'h01, 8'h22, 2'h1, 2'h3, 2'h1, 3'h4, 3'h0, 0, 0};
		rows[3] = '{0, 0, 8'h00, 8'h03, 8'h22, 2'h2, 2'h0, 2'h2, 3'h3, 3'h4, 0, 0};
		rows[4] = '{1, 1, 8'h10, 8'h02, 8'h02, 2'h1, 2'h0, 2'h0, 3'h0, 3'h4, 1, 1};
		rows[5] = '{1, 1, 8'h08, 8'h00, 8'h20, 2'h0, 2'h3, 2'h3, 3'h0, 3'h0, 1, 1};
		rows[6] = '{1, 1, 8'h00, 8'h03, 8'h00, 2'h1, 2'h0, 2'h2, 3'h3, 3'h3, 1, 1};
		// Straps: switching on, per port, active-high, charge on port 1.
		do_reset('{psw_n: 0, ganged: 0, polarity: 1, bus_mode_n: 0, charge: 2'b01});
		chk("bus mode strap", 16'h0000, {15'h0000, bus_mode_n});
		reg_rd(8'h05, 8'h00);
		reg_rd(8'h06, 8'h01);
		reg_rd(8'h0a, 8'h20);
		reg_rd(8'h09, 8'h00);
		reg_wr(8'h09, 8'h5a);
		reg_rd(8'h09, 8'h00);
		// ----------------------------------------------------------------
		// Table of speed, power and charging cases.
		// ----------------------------------------------------------------
		foreach (rows[i]) begin
			up_ss = rows[i].ss;
			up_hs = rows[i].hs;
			pwr_req = rows[i].req;
			wants = rows[i].div;
			act_hi = rows[i].r0a[5];
			reg_wr(8'h05, rows[i].r05);
			reg_wr(8'h06, rows[i].r06);
			reg_wr(8'h0a, rows[i].r0a);
			settle();
			reg_rd(8'h0a, rows[i].r0a);
			chk("ss enable", {15'h0000, rows[i].ss_e}, {15'h0000, ss_en});
			chk("hs enable", {15'h0000, rows[i].hs_e}, {15'h0000, hs_en});
			chk("power enables", {14'h0000, rows[i].pwr}, {14'h0000, pwr_en});
			chk("mode port 1", {13'h0000, rows[i].m0}, {13'h0000, chg_mode[0]});
			chk("mode port 2", {13'h0000, rows[i].m1}, {13'h0000, chg_mode[1]});
			chk("data line drive", {14'h0000, rows[i].m1 != 3'h0, rows[i].m0 != 3'h0},
				{14'h0000, dpdm});
		end
		// ----------------------------------------------------------------
		// Programmable memory reach and inverted removable bits.
		// ----------------------------------------------------------------
		otp_wr(8'h07, 8'h01);
		otp_wr(8'h01, 8'hab);
		otp_wr(8'h02, 8'hcd);
		otp_wr(8'h03, 8'h12);
		otp_wr(8'h04, 8'h34);
		otp_wr(8'h0a, 8'hff);
		otp_wr(8'h05, 8'hff);
		otp_wr(8'h06, 8'hff);
		otp_wr(8'hf2, 8'hff);
		settle();
		chk("removable", 16'h0002, {14'h0000, removable});
		chk("vendor id", 16'hcdab, vid);
		chk("product id", 16'h3412, pid);
		chk("power on delay", 16'h0007, {13'h0000, dly});
		reg_rd(8'h0a, 8'h12);
		reg_rd(8'h05, 8'h00);
		reg_rd(8'h06, 8'h03);
		reg_rd(8'hf2, 8'h0e);
		reg_wr(8'hf2, 8'h0a);
		settle();
		chk("power on delay", 16'h0005, {13'h0000, dly});
		// ----------------------------------------------------------------
		// Second reset with the opposite straps.
		// ----------------------------------------------------------------
		do_reset('{psw_n: 1, ganged: 1, polarity: 0, bus_mode_n: 1, charge: 2'b10});
		chk("bus mode strap", 16'h0001, {15'h0000, bus_mode_n});
		reg_rd(8'h05, 8'h18);
		reg_rd(8'h06, 8'h02);
		reg_rd(8'h0a, 8'h00);
		chk("power enables", 16'h0000, {14'h0000, pwr_en});
		end_of_test();
	end
endmodule : hcp_config_tb
